/* fcs_regs.vh */
// Register offsets, field positions, reset values and encodings of the clock source selector
`ifndef FCS_REGS_VH
`define FCS_REGS_VH

// ****************************************************************
// Register byte offsets on the bus
// ****************************************************************
`define FCS_ADDR_CTRL_ONE 4'h0
`define FCS_ADDR_CTRL_TWO 4'h4
`define FCS_ADDR_STATUS 4'h8

// ****************************************************************
// Control one fields
// ****************************************************************
`define FCS_SRC_HI 7
`define FCS_SRC_LO 6
`define FCS_REFERENCE_DIVIDER_FIELD_HI 5
`define FCS_REFERENCE_DIVIDER_FIELD_LO 3
`define FCS_REFSEL_BIT 2
`define FCS_IREN_BIT 1
`define FCS_IRSTEN_BIT 0
`define FCS_CTRL_ONE_RESET 8'h04

// ****************************************************************
// Control two fields
// ****************************************************************
`define FCS_BUS_DIVIDER_FIELD_HI 7
`define FCS_BUS_DIVIDER_FIELD_LO 6
`define FCS_RANGE_BIT 5
`define FCS_GAIN_BIT 4
`define FCS_LP_BIT 3
`define FCS_KIND_BIT 2
`define FCS_EREN_BIT 1
`define FCS_ERSTEN_BIT 0
`define FCS_CTRL_TWO_RESET 8'h40

// ****************************************************************
// Status fields
// ****************************************************************
`define FCS_STAT_HI 3
`define FCS_STAT_LO 2

// ****************************************************************
// Source select encodings
// ****************************************************************
`define FCS_SRC_LOOP 2'h0
`define FCS_SRC_INT 2'h1
`define FCS_SRC_EXT 2'h2
`define FCS_SRC_RSVD 2'h3

`endif

/* fcs_pow2_div.v */
// Power-of-two divider of a one-cycle tick stream
`timescale 1ns/1ns

module fcs_pow2_div (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // Control
  input wire i_clr,
  input wire [2:0] i_shift,
  // Ticks
  input wire i_tick,
  output reg o_tick
);

  reg [6:0] cnt_reg;
  wire [6:0] mask;

  assign mask = (7'h7f >> (3'h7 - i_shift));

  // ****************************************************************
  // Counter and output pulse
  // ****************************************************************
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= 7'h00;
      o_tick <= 1'b0;
    end else if (i_clr) begin
      cnt_reg <= 7'h00;
      o_tick <= 1'b0;
    end else begin
      o_tick <= i_tick && ((cnt_reg & mask) == mask);
      if (i_tick) begin
        cnt_reg <= cnt_reg + 7'h01;
      end
    end
  end

endmodule // fcs_pow2_div

/* fcs_clock_select.v */
// Clock source selector: loop, internal or external reference, dividers, Wishbone registers
`timescale 1ns/1ns
`include "fcs_regs.vh"

// Behaviour
// - Bus clock runs at half the final divided clock rate.
// - Source select 00 loop, 01 internal, 10 external; 11 acts as 00.
// - Reference divider divides loop reference by 2^code, 1 to 128, resets 000.
// - Reference select 1 feeds loop from internal, 0 from external reference.
// - Internal reference enable drives internal reference output; off keeps it inactive.
// - In stop internal reference runs only with stop enable and enable or internal mode.
// - Reset enters engaged-internal: system clock from loop on internal reference.
// - Engaged-external: system clock from loop on external reference, debug from loop.
// - Bypassed-internal: loop runs on reference per reference select, system clock internal reference.
// - Bypassed-internal-low-power: loop off, system clock internal, no debug clock.
// - Bypassed-external: loop runs on reference per reference select, system clock external reference.
// - Bypassed-external-low-power: loop off, system clock external, no debug clock.
// - Stop: loop off, no system or debug clock, references per stop enables.
// - Debug clock is the loop oscillator divided by two.
// - Selected source passes a bus divider of 1, 2, 4 or 8.
// - Oscillator controls out: gain, range, kind, external enable, external stop enable.
// - External reference up to 5 MHz may control the loop.
// - Bus divider 00 /1, 01 /2, 10 /4, 11 /8; resets to /2.
// - Clock mode status follows source select only after synchronisation.
module fcs_clock_select (
  // Clock and reset
  input wire I_REF_CLK,
  input wire I_RST_B,
  // Wishbone slave
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [3:0] I_WB_ADR,
  input wire [3:0] I_WB_SEL,
  input wire [31:0] I_WB_DAT,
  output reg [31:0] O_WB_DAT,
  output reg O_WB_ACK,
  // Source ticks and stop request
  input wire I_DCO_TICK,
  input wire I_INT_REF_TICK,
  input wire I_EXT_REF_TICK,
  input wire I_STOP,
  // Clock enables out
  output reg O_FINAL_CLK,
  output reg O_BUS_CLK,
  output reg O_DEBUG_CLK,
  output reg O_INT_REF_OUT,
  output reg O_LOOP_REF_TICK,
  // Loop and reference control
  output reg O_LOOP_ENABLE,
  output reg O_INT_REF_RUN,
  // Low-power oscillator control
  output reg O_OSC_GAIN,
  output reg O_OSC_RANGE,
  output reg O_OSC_KIND,
  output reg O_EXT_REF_EN,
  output reg O_EXT_REF_STOP_EN
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [7:0] ctrl_one_reg;
  reg [7:0] ctrl_two_reg;
  reg [1:0] sel_meta_reg;
  reg [1:0] sel_sync_reg;
  reg [1:0] src_reg;
  reg [1:0] src_next;
  reg stop_int_mode_reg;
  reg stop_ext_mode_reg;
  reg bus_half_reg;
  reg dbg_half_reg;
  reg sel_tick;
  reg loop_ref_raw;

  wire [1:0] src_field;
  wire [2:0] reference_divider_field_field;
  wire [1:0] bus_divider_field_field;
  wire ref_sel;
  wire ir_en;
  wire ir_stop_en;
  wire low_power;
  wire er_en;
  wire er_stop_en;
  wire bypassed;
  wire loop_on;
  wire int_mode;
  wire ext_mode;
  wire int_run;
  wire ext_run;
  wire switch_now;
  wire bus_div_tick;
  wire ref_div_tick;
  wire wb_req;
  wire [7:0] wr_byte;

  assign src_field = ctrl_one_reg[`FCS_SRC_HI:`FCS_SRC_LO];
  assign reference_divider_field_field = ctrl_one_reg[`FCS_REFERENCE_DIVIDER_FIELD_HI:`FCS_REFERENCE_DIVIDER_FIELD_LO];
  assign ref_sel = ctrl_one_reg[`FCS_REFSEL_BIT];
  assign ir_en = ctrl_one_reg[`FCS_IREN_BIT];
  assign ir_stop_en = ctrl_one_reg[`FCS_IRSTEN_BIT];
  assign bus_divider_field_field = ctrl_two_reg[`FCS_BUS_DIVIDER_FIELD_HI:`FCS_BUS_DIVIDER_FIELD_LO];
  assign low_power = ctrl_two_reg[`FCS_LP_BIT];
  assign er_en = ctrl_two_reg[`FCS_EREN_BIT];
  assign er_stop_en = ctrl_two_reg[`FCS_ERSTEN_BIT];

  assign wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  assign wr_byte = I_WB_DAT[7:0];

  // ****************************************************************
  // Wishbone slave, one wait state, unmapped reads zero
  // ****************************************************************
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_one_reg <= `FCS_CTRL_ONE_RESET;
      ctrl_two_reg <= `FCS_CTRL_TWO_RESET;
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h00000000;
    end else begin
      O_WB_ACK <= wb_req;
      O_WB_DAT <= 32'h00000000;
      if (wb_req) begin
        if (I_WB_ADR == `FCS_ADDR_CTRL_ONE) begin
          O_WB_DAT <= {24'h000000, ctrl_one_reg};
          if (I_WB_WE && I_WB_SEL[0]) begin
            ctrl_one_reg <= wr_byte;
          end
        end else if (I_WB_ADR == `FCS_ADDR_CTRL_TWO) begin
          O_WB_DAT <= {24'h000000, ctrl_two_reg};
          if (I_WB_WE && I_WB_SEL[0]) begin
            ctrl_two_reg <= wr_byte;
          end
        end else if (I_WB_ADR == `FCS_ADDR_STATUS) begin
          O_WB_DAT <= {28'h0000000, src_reg, 2'h0};
        end
      end
    end
  end

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  assign bypassed = (src_reg != `FCS_SRC_LOOP);
  // Loop off in stop and in low-power bypass
  assign loop_on = !I_STOP && !(bypassed && low_power);
  // Internal modes: engaged-internal, bypassed-internal and its low-power form
  assign int_mode = (src_reg == `FCS_SRC_INT) || (!bypassed && ref_sel);
  assign ext_mode = (src_reg == `FCS_SRC_EXT) || (!bypassed && !ref_sel);
  assign int_run = I_STOP ? (ir_stop_en && (ir_en || stop_int_mode_reg))
                          : (ir_en || int_mode || (loop_on && ref_sel));
  assign ext_run = I_STOP ? (er_stop_en && (er_en || stop_ext_mode_reg))
                          : (er_en || ext_mode || (loop_on && !ref_sel));

  // Mode held from before stop decides which reference may keep running
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      stop_int_mode_reg <= 1'b1;
      stop_ext_mode_reg <= 1'b0;
    end else if (!I_STOP) begin
      stop_int_mode_reg <= int_mode;
      stop_ext_mode_reg <= ext_mode;
    end
  end

  // ****************************************************************
  // Source select synchroniser and glitch-free switch
  // ****************************************************************
  // New source is taken only right after a full output period, or while stopped,
  // and the bus divider restarts so the first period of the new source is whole
  assign switch_now = (src_next != src_reg) && (bus_div_tick || I_STOP);

  always @* begin
    src_next = sel_sync_reg;
    if (sel_sync_reg == `FCS_SRC_RSVD) begin
      src_next = `FCS_SRC_LOOP;
    end
  end

  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sel_meta_reg <= `FCS_SRC_LOOP;
      sel_sync_reg <= `FCS_SRC_LOOP;
      src_reg <= `FCS_SRC_LOOP;
    end else begin
      sel_meta_reg <= src_field;
      sel_sync_reg <= sel_meta_reg;
      if (src_next != src_reg && (bus_div_tick || I_STOP)) begin
        src_reg <= src_next;
      end
    end
  end

  // ****************************************************************
  // Source multiplexer
  // ****************************************************************
  always @* begin
    sel_tick = 1'b0;
    if (!I_STOP) begin
      if (src_reg == `FCS_SRC_INT) begin
        sel_tick = I_INT_REF_TICK;
      end else if (src_reg == `FCS_SRC_EXT) begin
        sel_tick = I_EXT_REF_TICK;
      end else begin
        sel_tick = I_DCO_TICK;
      end
    end
  end

  // Loop reference: internal when select is set, external otherwise
  always @* begin
    loop_ref_raw = 1'b0;
    if (loop_on) begin
      if (ref_sel) begin
        loop_ref_raw = I_INT_REF_TICK;
      end else begin
        loop_ref_raw = I_EXT_REF_TICK;
      end
    end
  end

  // ****************************************************************
  // Dividers
  // ****************************************************************
  fcs_pow2_div u_bus_div (
    .i_clk(I_REF_CLK),
    .i_rst_b(I_RST_B),
    .i_clr(switch_now || I_STOP),
    .i_shift({1'b0, bus_divider_field_field}),
    .i_tick(sel_tick),
    .o_tick(bus_div_tick)
  );

  fcs_pow2_div u_ref_div (
    .i_clk(I_REF_CLK),
    .i_rst_b(I_RST_B),
    .i_clr(!loop_on),
    .i_shift(reference_divider_field_field),
    .i_tick(loop_ref_raw),
    .o_tick(ref_div_tick)
  );

  // ****************************************************************
  // Output clock enables and control lines
  // ****************************************************************
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_FINAL_CLK <= 1'b0;
      O_BUS_CLK <= 1'b0;
      O_DEBUG_CLK <= 1'b0;
      O_INT_REF_OUT <= 1'b0;
      O_LOOP_REF_TICK <= 1'b0;
      O_LOOP_ENABLE <= 1'b0;
      O_INT_REF_RUN <= 1'b0;
      O_OSC_GAIN <= 1'b0;
      O_OSC_RANGE <= 1'b0;
      O_OSC_KIND <= 1'b0;
      O_EXT_REF_EN <= 1'b0;
      O_EXT_REF_STOP_EN <= 1'b0;
      bus_half_reg <= 1'b0;
      dbg_half_reg <= 1'b0;
    end else begin
      O_FINAL_CLK <= bus_div_tick && !I_STOP;
      O_BUS_CLK <= 1'b0;
      if (I_STOP) begin
        bus_half_reg <= 1'b0;
      end else if (bus_div_tick) begin
        bus_half_reg <= !bus_half_reg;
        O_BUS_CLK <= bus_half_reg;
      end
      O_DEBUG_CLK <= 1'b0;
      if (!loop_on) begin
        dbg_half_reg <= 1'b0;
      end else if (I_DCO_TICK) begin
        dbg_half_reg <= !dbg_half_reg;
        O_DEBUG_CLK <= dbg_half_reg;
      end
      O_INT_REF_OUT <= I_INT_REF_TICK && ir_en && int_run;
      O_LOOP_REF_TICK <= ref_div_tick && loop_on;
      O_LOOP_ENABLE <= loop_on;
      O_INT_REF_RUN <= int_run;
      O_OSC_GAIN <= ctrl_two_reg[`FCS_GAIN_BIT];
      O_OSC_RANGE <= ctrl_two_reg[`FCS_RANGE_BIT];
      O_OSC_KIND <= ctrl_two_reg[`FCS_KIND_BIT];
      O_EXT_REF_EN <= ext_run;
      O_EXT_REF_STOP_EN <= er_stop_en;
    end
  end

endmodule // fcs_clock_select

/* fcs_monitor.sv */
// Port checker of the clock source selector
`timescale 1ns/1ns
module fcs_monitor (
  // Clock, reset and bus
  input wire I_REF_CLK,
  input wire I_RST_B,
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [3:0] I_WB_ADR,
  input wire [3:0] I_WB_SEL,
  input wire [31:0] I_WB_DAT,
  input wire O_WB_ACK,
  // Ticks and clock outputs
  input wire I_DCO_TICK,
  input wire I_INT_REF_TICK,
  input wire I_EXT_REF_TICK,
  input wire I_STOP,
  input wire O_FINAL_CLK,
  input wire O_BUS_CLK,
  input wire O_DEBUG_CLK,
  input wire O_INT_REF_OUT,
  input wire O_LOOP_REF_TICK,
  input wire O_LOOP_ENABLE,
  input wire O_OSC_GAIN
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);
  sequence s_take; I_WB_CYC && I_WB_STB && !O_WB_ACK; endsequence
  sequence s_wr_two; O_WB_ACK && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == 4'h4; endsequence
  sequence s_stopped; I_STOP [*3]; endsequence
  property p_ack; s_take |=> O_WB_ACK ##1 !O_WB_ACK; endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle");
  property p_bus; O_BUS_CLK |-> O_FINAL_CLK; endproperty
  a_bus: assert property (p_bus) else $error("bus tick without final tick");
  property p_stop; s_stopped |-> !O_FINAL_CLK && !O_BUS_CLK && !O_DEBUG_CLK && !O_LOOP_ENABLE;
  endproperty
  a_stop: assert property (p_stop) else $error("clock out during stop");
  property p_dbg; O_DEBUG_CLK |-> $past(I_DCO_TICK); endproperty
  a_dbg: assert property (p_dbg) else $error("debug tick without loop tick");
  property p_lp; !O_LOOP_ENABLE [*3] |-> !O_DEBUG_CLK; endproperty
  a_lp: assert property (p_lp) else $error("debug tick with loop off");
  property p_iro; O_INT_REF_OUT |-> $past(I_INT_REF_TICK); endproperty
  a_iro: assert property (p_iro) else $error("internal output without tick");
  property p_lref; O_LOOP_REF_TICK |-> $past(I_INT_REF_TICK, 2) || $past(I_EXT_REF_TICK, 2);
  endproperty
  a_lref: assert property (p_lref) else $error("loop reference tick unexplained");
  property p_osc; s_wr_two |=> O_OSC_GAIN == $past(I_WB_DAT[4]); endproperty
  a_osc: assert property (p_osc) else $error("gain select not copied");
  property p_rst; $rose(I_RST_B) |=> O_LOOP_ENABLE; endproperty
  a_rst: assert property (p_rst) else $error("loop off after reset");
endmodule // fcs_monitor

bind fcs_clock_select fcs_monitor u_fcs_monitor (.I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B),
  .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
  .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_DCO_TICK(I_DCO_TICK),
  .I_INT_REF_TICK(I_INT_REF_TICK), .I_EXT_REF_TICK(I_EXT_REF_TICK), .I_STOP(I_STOP),
  .O_FINAL_CLK(O_FINAL_CLK), .O_BUS_CLK(O_BUS_CLK), .O_DEBUG_CLK(O_DEBUG_CLK),
  .O_INT_REF_OUT(O_INT_REF_OUT), .O_LOOP_REF_TICK(O_LOOP_REF_TICK),
  .O_LOOP_ENABLE(O_LOOP_ENABLE), .O_OSC_GAIN(O_OSC_GAIN));

/* fcs_tick_src.sv */
// Tick source standing in for an oscillator or reference clock
`timescale 1ns/1ns
module fcs_tick_src (
  // Clock
  input wire i_clk,
  // Ticks every i_period plus one cycles
  input wire [3:0] i_period,
  output reg o_tick
);
  integer cnt = 0;
  initial o_tick = 1'b0;
  always @(posedge i_clk) begin
    cnt <= (cnt >= i_period) ? 0 : cnt + 1;
    o_tick <= (cnt == 0);
  end
endmodule // fcs_tick_src

/* testbench.sv */
// Self-checking bench of the clock source selector
`timescale 1ns/1ns
module testbench;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg stop = 1'b0;
  reg [3:0] adr = 4'h0;
  reg [3:0] sel = 4'h0;
  reg [31:0] dat = 32'h0;
  reg [3:0] dp = 4'h1;
  reg [3:0] ip = 4'h0;
  reg [3:0] ep = 4'h3;
  wire [31:0] rdat;
  wire ack, fin, bus, dbg, iro, lref, len, irun, gain, rng, kind, eren, ersten, dco, itk, etk;
  wire [4:0] sig = {iro, lref, dbg, bus, fin};
  integer bad_count = 0;
  integer total_checks = 0;
  integer i, g, j;
  reg [31:0] q;
  reg [7:0] r;
  initial forever #25 clk = ~clk;
  fcs_tick_src u_dco (.i_clk(clk), .i_period(dp), .o_tick(dco));
  // Internal reference ticks stand for an oscillator already trimmed by software
  fcs_tick_src u_int (.i_clk(clk), .i_period(ip), .o_tick(itk));
  fcs_tick_src u_ext (.i_clk(clk), .i_period(ep), .o_tick(etk));
  fcs_clock_select u_fcs_clock_select (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_DCO_TICK(dco), .I_INT_REF_TICK(itk),
    .I_EXT_REF_TICK(etk), .I_STOP(stop), .O_FINAL_CLK(fin), .O_BUS_CLK(bus),
    .O_DEBUG_CLK(dbg), .O_INT_REF_OUT(iro), .O_LOOP_REF_TICK(lref), .O_LOOP_ENABLE(len),
    .O_INT_REF_RUN(irun), .O_OSC_GAIN(gain), .O_OSC_RANGE(rng), .O_OSC_KIND(kind),
    .O_EXT_REF_EN(eren), .O_EXT_REF_STOP_EN(ersten));
  task results;
    begin
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk_reg(input string nm, input [31:0] e, input [31:0] s);
    begin
      total_checks++;
      if (s !== e) begin
        bad_count++;
        $display("ERROR %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // Second gap between pulses of one output, -1 when it stays silent
  task chk_gap(input string nm, input integer k, input integer e);
    integer n, t;
    begin
      for (j = 0; j < 2; j++) begin
        g = -1;
        t = -1;
        for (n = 0; n < 300 && g < 0; n++) begin
          @(posedge clk);
          if (sig[k] === 1'b1) begin
            if (t >= 0) g = n - t;
            t = n;
          end
        end
      end
      total_checks++;
      if (g != e) begin
        bad_count++;
        $display("ERROR %s expected %0d seen %0d", nm, e, g);
      end
    end
  endtask
  task wb(input w, input [3:0] a, input [7:0] d, input s0);
    integer n;
    begin
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= {3'h0, s0};
      dat <= {24'h0, d};
      n = 0;
      @(posedge clk);
      while (ack !== 1'b1) begin
        n++;
        if (n > 20) bad_count++;
        if (n > 20) results;
        @(posedge clk);
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
    end
  endtask
  initial begin
    i = $urandom(32'h7ca01206);
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 4; i++) begin
      wb(0, i * 4, 8'h0, 1'b0);
      chk_reg("reset", i == 0 ? 4 : i == 1 ? 'h40 : 0, q);
    end
    r = $urandom;
    wb(1, 4'h0, r, 1'b1);
    wb(1, 4'h0, ~r, 1'b0);
    wb(0, 4'h0, 8'h0, 1'b0);
    chk_reg("ctrl_one", r, q);
    r = $urandom;
    wb(1, 4'h4, r, 1'b1);
    chk_reg("osc", {r[4], r[5], r[2], r[0]}, {gain, rng, kind, ersten});
    wb(1, 4'h0, 8'h04, 1'b1);
    for (i = 0; i < 4; i++) begin
      wb(1, 4'h4, i << 6, 1'b1);
      chk_gap("final", 0, 2 << i);
      chk_gap("bus", 1, 4 << i);
    end
    chk_gap("debug", 2, 4);
    for (i = 0; i < 8; i++) begin
      wb(1, 4'h0, (i << 3) | 4, 1'b1);
      chk_gap("loop_ref", 3, 1 << i);
    end
    wb(1, 4'h0, 8'h08, 1'b1);
    chk_gap("loop_ref", 3, 8);
    ip <= 4'h2;
    wb(1, 4'h0, 8'h06, 1'b1);
    chk_gap("int_out", 4, 3);
    // Bus divider back to one so each source shows its own tick spacing
    wb(1, 4'h4, 8'h00, 1'b1);
    for (i = 0; i < 4; i++) begin
      wb(1, 4'h0, (i << 6) | 4, 1'b1);
      q = 32'hf;
      for (j = 0; j < 20 && q[3:2] !== i % 3; j++) wb(0, 4'h8, 8'h0, 1'b0);
      chk_reg("status", i % 3, q[3:2]);
      chk_gap("final", 0, i == 1 ? 3 : i == 2 ? 4 : 2);
    end
    chk_gap("int_out", 4, -1);
    wb(1, 4'h0, 8'h44, 1'b1);
    wb(1, 4'h4, 8'h08, 1'b1);
    chk_gap("debug", 2, -1);
    wb(1, 4'h4, 8'h00, 1'b1);
    chk_gap("debug", 2, 4);
    wb(1, 4'h0, 8'h80, 1'b1);
    wb(1, 4'h4, 8'h08, 1'b1);
    chk_gap("debug", 2, -1);
    // Engaged-internal with internal enable off: only the mode keeps it running in stop
    wb(1, 4'h0, 8'h05, 1'b1);
    q = 32'hf;
    for (j = 0; j < 20 && q[3:2] !== 2'h0; j++) wb(0, 4'h8, 8'h0, 1'b0);
    stop <= 1'b1;
    chk_gap("final", 0, -1);
    chk_reg("int_run", 1, irun);
    chk_reg("ext_run", 0, eren);
    chk_reg("loop_en", 0, len);
    wb(1, 4'h0, 8'h06, 1'b1);
    chk_gap("debug", 2, -1);
    chk_reg("int_run", 0, irun);
    stop <= 1'b0;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    wb(0, 4'h0, 8'h0, 1'b0);
    chk_reg("ctrl_one", 4, q);
    wb(0, 4'h4, 8'h0, 1'b0);
    chk_reg("ctrl_two", 'h40, q);
    results;
  end
endmodule // testbench
